// *** crf_cfg.svh ***
// Constants for the clear-file-register execution block
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
`define CRF_OPC_HI 7'h35
`define CRF_ZERO_DATA 8'h00
`define CRF_ILO_LIMIT 8'h5F
`define CRF_ACC_SPLIT 8'h60
`define CRF_ACC_HI_BANK 4'hF
`define CRF_ACC_LO_BANK 4'h0
`define CRF_REG_CTRL 32'h00000000
`define CRF_REG_INSN 32'h00000004
`define CRF_REG_BANK 32'h00000008
`define CRF_REG_IBASE 32'h0000000C
`define CRF_REG_STAT 32'h00000010
`define CRF_REG_ADDR 32'h00000014
`define CRF_REG_DATA 32'h00000018
`define CRF_BIT_GO 0
`define CRF_BIT_XINST 1
`define CRF_BIT_ZERO 0
`define CRF_BIT_BUSY 1
`define CRF_BIT_BADOP 2
`define CRF_BIT_ZCLR 1
`define CRF_RAM_WORDS 4096
`endif

// *** crf_clear_register_exec.sv ***
// Clear-file-register instruction execution with a Wishbone register port
`timescale 1ns/10ps
`default_nettype none
`include "crf_cfg.svh"

// Notes on behaviour
// (RULE1) The instruction writes zero into the addressed register and sets only the zero flag.
// (RULE2) With the access bit low the 8-bit operand addresses the fixed access bank.
// (RULE3) With the access bit high the bank comes from the bank select register.
// (RULE4) With the access bit low and extended set on, operands up to 5Fh are index offsets.
// (RULE5) Q1 decodes, Q2 reads the target, Q3 processes, Q4 writes the target.
// (RULE6) One program word, one instruction cycle, no stall or flush afterwards.
module crf_clear_register_exec (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core status
  output logic zero_flag_o,
  output logic busy_o
);
  import crf_pkg::*;

  crf_mem_if mem_bus ();

  logic [15:0] insn_r;
  logic [3:0] bank_r;
  logic [11:0] ibase_r;
  logic xinst_r;
  logic zero_r;
  logic badop_r;
  logic [11:0] addr_r;
  logic [7:0] old_data_r;
  logic ack_r;
  logic [31:0] dat_r;
  crf_q_t q_r;
  crf_q_t q_nxt;
  logic wb_req;
  logic wr_go;
  logic is_clear_op;

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------

  // Effective address of an 8-bit operand; computed at decode and latched in addr_r for the readback view
  // The indexed sum wraps inside the 4 KiB space; the carry out is dropped on purpose
  function automatic logic [11:0] crf_ea(input logic [7:0] f, input logic acc,
                                         input logic xi, input logic [3:0] bank_sel,
                                         input logic [11:0] ibase);
    logic [11:0] ea;
    ea = 12'h000;
    if (acc) begin
      ea = {bank_sel, f}; // RULE3
    end else if (xi && (f <= `CRF_ILO_LIMIT)) begin
      ea = ibase + {4'h0, f}; // RULE4
    end else if (f < `CRF_ACC_SPLIT) begin
      ea = {`CRF_ACC_LO_BANK, f}; // RULE2
    end else begin
      ea = {`CRF_ACC_HI_BANK, f}; // RULE2
    end
    return ea;
  endfunction

  assign is_clear_op = (insn_r[15:9] == `CRF_OPC_HI);

  // ----------------------------------------------------------------
  // Quarter-cycle sequencer
  // ----------------------------------------------------------------

  // Four quarter-cycles then straight back to idle: no extra stall state
  always_comb begin
    q_nxt = q_r;
    case (q_r)
      CRF_IDLE: begin
        if (wr_go) begin
          q_nxt = CRF_Q1;
        end
      end
      CRF_Q1: q_nxt = CRF_Q2; // RULE5
      CRF_Q2: q_nxt = CRF_Q3; // RULE5
      CRF_Q3: q_nxt = CRF_Q4; // RULE5
      CRF_Q4: q_nxt = CRF_IDLE; // RULE6
      default: q_nxt = CRF_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= CRF_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Q1 decode latches the target address; a bad opcode is flagged and skipped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r <= 12'h000;
      badop_r <= 1'b0;
    end else if (q_r == CRF_Q1) begin
      addr_r <= crf_ea(insn_r[7:0], insn_r[8], xinst_r, bank_r, ibase_r); // RULE5
      badop_r <= !is_clear_op;
    end else if (wr_go) begin
      badop_r <= 1'b0;
    end
  end

  // Q3 captures the old contents, read during Q2, for software inspection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      old_data_r <= `CRF_ZERO_DATA;
    end else if (q_r == CRF_Q3 && !badop_r) begin
      old_data_r <= mem_bus.rdata; // RULE5
    end
  end

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------

  // Memory channel: address held from Q2, write strobe in Q4 only
  assign mem_bus.addr = addr_r; // RULE5
  assign mem_bus.we = (q_r == CRF_Q4) && !badop_r; // RULE5
  assign mem_bus.wdata = `CRF_ZERO_DATA; // RULE1

  crf_file_store u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mem(mem_bus)
  );

  // ----------------------------------------------------------------
  // Status flag
  // ----------------------------------------------------------------

  // Zero flag: set by the write; software clear loses to a same-cycle set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_r <= 1'b0;
    end else if (mem_bus.we) begin
      zero_r <= 1'b1; // RULE1
    end else if (wb_req && we_i && adr_i == `CRF_REG_STAT && sel_i[0] &&
                 dat_i[`CRF_BIT_ZCLR]) begin
      zero_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone register port
  // ----------------------------------------------------------------

  // One-cycle answer; ack drops the cycle after so each access acks once
  assign wb_req = cyc_i && stb_i && !ack_r;
  assign wr_go = wb_req && we_i && adr_i == `CRF_REG_CTRL && sel_i[0] &&
                 dat_i[`CRF_BIT_GO] && (q_r == CRF_IDLE);

  // Writable configuration; instruction word ignored while executing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insn_r <= 16'h0000;
      bank_r <= 4'h0;
      ibase_r <= 12'h000;
      xinst_r <= 1'b0;
    end else if (wb_req && we_i) begin
      if (adr_i == `CRF_REG_CTRL && sel_i[0]) begin
        xinst_r <= dat_i[`CRF_BIT_XINST];
      end else if (adr_i == `CRF_REG_INSN && q_r == CRF_IDLE) begin
        if (sel_i[0]) insn_r[7:0] <= dat_i[7:0];
        if (sel_i[1]) insn_r[15:8] <= dat_i[15:8];
      end else if (adr_i == `CRF_REG_BANK && sel_i[0]) begin
        bank_r <= dat_i[3:0];
      end else if (adr_i == `CRF_REG_IBASE) begin
        if (sel_i[0]) ibase_r[7:0] <= dat_i[7:0];
        if (sel_i[1]) ibase_r[11:8] <= dat_i[11:8];
      end
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= wb_req;
      dat_r <= 32'h00000000;
      if (wb_req && !we_i) begin
        if (adr_i == `CRF_REG_CTRL) begin
          dat_r <= {30'h0, xinst_r, 1'b0};
        end else if (adr_i == `CRF_REG_INSN) begin
          dat_r <= {16'h0000, insn_r};
        end else if (adr_i == `CRF_REG_BANK) begin
          dat_r <= {28'h0000000, bank_r};
        end else if (adr_i == `CRF_REG_IBASE) begin
          dat_r <= {20'h00000, ibase_r};
        end else if (adr_i == `CRF_REG_STAT) begin
          dat_r <= {29'h0, badop_r, q_r != CRF_IDLE, zero_r};
        end else if (adr_i == `CRF_REG_ADDR) begin
          dat_r <= {20'h00000, addr_r};
        end else if (adr_i == `CRF_REG_DATA) begin
          dat_r <= {24'h000000, old_data_r};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Bus outputs come straight from flops; busy decodes the state register
  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign zero_flag_o = zero_r;
  assign busy_o = (q_r != CRF_IDLE);
endmodule
`default_nettype wire

// *** crf_clear_register_exec_sva.sv ***
// Checker for the clear-file-register execution block
`timescale 1ns/10ps
`default_nettype none
module crf_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and status
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic zero_flag_o,
  input wire logic busy_o
);
  // Shadow of the opcode taken while idle; a bad word must not move the flag
  logic op_ok_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_ok_r <= 1'b0;
    end else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 32'h4 && sel_i[1] &&
                 !busy_o) begin
      op_ok_r <= (dat_i[15:9] == 7'h35);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Go write taken while idle, then the four quarter-cycles
  sequence s_go;
    cyc_i && stb_i && we_i && !ack_o && adr_i == 32'h0 && sel_i[0] && dat_i[0] && !busy_o;
  endsequence
  sequence s_quads;
    busy_o [*4] ##1 !busy_o;
  endsequence
  property p_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  property p_quads;
    s_go |=> s_quads;
  endproperty
  property p_zset;
    $fell(busy_o) && op_ok_r |-> zero_flag_o;
  endproperty
  property p_zrise;
    $rose(zero_flag_o) |-> $fell(busy_o) && op_ok_r;
  endproperty
  // Only a status write may drop the flag; request is checked one sample back
  property p_zfall;
    $fell(zero_flag_o) |-> $past(cyc_i && we_i && adr_i == 32'h10);
  endproperty
  property p_start;
    $rose(busy_o) |-> ack_o && $past(we_i && adr_i == 32'h0);
  endproperty
  property p_idle;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_quads: assert property (p_quads) else $error("busy not four cycles");
  a_zset: assert property (p_zset) else $error("zero flag not set at end");
  a_zrise: assert property (p_zrise) else $error("zero flag set early");
  a_zfall: assert property (p_zfall) else $error("zero flag dropped");
  a_start: assert property (p_start) else $error("busy without go");
  a_idle: assert property (p_idle) else $error("read data outside ack");
endmodule
bind crf_clear_register_exec crf_sva crf_sva_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .zero_flag_o, .busy_o);
`default_nettype wire

// *** crf_clear_register_exec_tb_top.sv ***
// Self-checking bench for the clear-file-register execution block
`timescale 1ns/10ps
`default_nettype none
`include "crf_cfg.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module crf_clear_register_exec_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [31:0] adr_i = 32'h0;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack_o;
  logic zero_flag_o;
  logic busy_o;
  int miscompares = 0;
  int checked = 0;
  // Extended set, bank, index base, opcode word, expected effective address
  logic [44:0] cases [7] = '{{1'h0, 4'h3, 12'h000, 16'h6B25, 12'h325},
    {1'h0, 4'h3, 12'h000, 16'h6A5F, 12'h05F}, {1'h0, 4'h3, 12'h000, 16'h6A60, 12'hF60},
    {1'h1, 4'h3, 12'h200, 16'h6A5F, 12'h25F}, {1'h1, 4'h3, 12'h200, 16'h6A00, 12'h200},
    {1'h1, 4'h5, 12'h200, 16'h6B60, 12'h560}, {1'h1, 4'h3, 12'h200, 16'h6A60, 12'hF60}};
  crf_clear_register_exec crf_clear_register_exec_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .zero_flag_o, .busy_o);
  // Clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Classic cycle: hold everything until ack is sampled, then release
  // A hung slave is ended by the watchdog alone, never by a local count
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'h3};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  // Launch the instruction and wait out its quarter-cycles
  task automatic go(input logic x);
    wb(1'b1, `CRF_REG_CTRL, {30'h0, x, 1'b1});
    repeat (5) @(posedge clk_i);
    `CHK(busy_o, 1'b0)
    `CHK(zero_flag_o, 1'b1)
  endtask
  task automatic test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic x;
    logic [3:0] b;
    logic [11:0] f2;
    logic [15:0] op;
    logic [11:0] ea;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `CRF_REG_STAT, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, 32'h40, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 7; i++) begin
      {x, b, f2, op, ea} = cases[i];
      wb(1'b1, `CRF_REG_STAT, 32'h2);
      wb(1'b1, `CRF_REG_CTRL, {30'h0, x, 1'b0});
      wb(1'b1, `CRF_REG_BANK, {28'h0, b});
      wb(1'b1, `CRF_REG_IBASE, {20'h0, f2});
      wb(1'b1, `CRF_REG_INSN, {16'h0, op});
      `CHK(zero_flag_o, 1'b0)
      go(x);
      wb(1'b0, `CRF_REG_ADDR, 32'h0);
      `CHK(rd, {20'h0, ea})
      go(x);
      wb(1'b0, `CRF_REG_DATA, 32'h0);
      `CHK(rd, 32'h0)
      wb(1'b0, `CRF_REG_STAT, 32'h0);
      `CHK(rd, 32'h1)
      $display("case %0d done", i);
    end
    // Bad opcode runs its quarter-cycles but writes nothing and leaves the flag
    wb(1'b1, `CRF_REG_STAT, 32'h2);
    wb(1'b1, `CRF_REG_INSN, 32'h0);
    wb(1'b1, `CRF_REG_CTRL, 32'h1);
    wb(1'b1, `CRF_REG_INSN, 32'h6A00);
    repeat (3) @(posedge clk_i);
    `CHK(busy_o, 1'b0)
    `CHK(zero_flag_o, 1'b0)
    wb(1'b0, `CRF_REG_INSN, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, `CRF_REG_STAT, 32'h0);
    `CHK(rd, 32'h4)
    $display("bad opcode done");
    test_done;
  end
  // Watchdog, far beyond the few hundred cycles the cases need
  initial begin
    #400000;
    miscompares++;
    test_done;
  end
endmodule
`default_nettype wire

// *** crf_file_store.sv ***
// Flip-flop file register store, 4096 bytes of data memory
`timescale 1ns/10ps
`default_nettype none
`include "crf_cfg.svh"
module crf_file_store (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Memory channel
  crf_mem_if.mem mem
);
  logic [7:0] store_r [0:`CRF_RAM_WORDS-1];
  logic [7:0] rdata_r;

  // Write port; storage is not reset, like real data memory
  always_ff @(posedge clk_i) begin
    if (mem.we) begin
      store_r[mem.addr] <= mem.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= `CRF_ZERO_DATA;
    end else begin
      rdata_r <= store_r[mem.addr];
    end
  end

  assign mem.rdata = rdata_r;
endmodule
`default_nettype wire

// *** crf_mem_if.sv ***
// Data-memory write/read channel between the core and the file register store
`timescale 1ns/10ps
`default_nettype none
interface crf_mem_if;
  logic [11:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// *** crf_pkg.sv ***
// Types shared by the clear-file-register block
`default_nettype none
package crf_pkg;
  typedef enum logic [2:0] {
    CRF_IDLE,
    CRF_Q1,
    CRF_Q2,
    CRF_Q3,
    CRF_Q4
  } crf_q_t;
endpackage
`default_nettype wire
